// ===== hdl/rcc_core.sv
`timescale 1ns/1ps
`include "rcc_defines.svh"
module rcc_core (
  input wire rcc_pkg::rcc_bit_t REF_CLK, // Core clock, 20 MHz
  input wire rcc_pkg::rcc_bit_t SRST, // Synchronous reset, active high
  input wire rcc_pkg::rcc_bit_t LINK_SCLK, // Serial shift clock from host
  input wire rcc_pkg::rcc_bit_t LINK_CE, // Serial frame enable
  input wire rcc_pkg::rcc_bit_t SIO_IN, // Serial data pin, input side
  output rcc_pkg::rcc_bit_t SIO_OUT, // Serial data pin, output side
  output rcc_pkg::rcc_bit_t SIO_OE, // Serial data pin drive enable
  input wire rcc_pkg::rcc_bit_t TICK_1HZ, // One-second tick from oscillator
  input wire rcc_pkg::rcc_bit_t SECOND_CARRY_GATE, // Lets ticks reach seconds
  input wire rcc_pkg::rcc_bit_t ALARM_OUTPUT_HALT, // Holds alarm output off
  input wire rcc_pkg::rcc_bit_t ALARM_ENABLE, // Enables alarm comparison
  input wire rcc_pkg::rcc_bit_t HOUR_24_MODE, // 24-hour hours when high
  input wire rcc_pkg::rcc_bit_t BANK_SELECT, // Alarm bank when high
  output rcc_pkg::rcc_bit_t INTERRUPT_OUT_N // Alarm interrupt, active low
);
  import rcc_pkg::*;
  rcc_core_t s;
  rcc_core_t next_s;
  rcc_link_if lk_if();
  logic tick_ev;
  logic wr_ev;
  logic gate;
  logic h24;
  logic [8:0] sec_nx;
  logic [8:0] min_nx;
  logic [6:0] hr_nx;
  logic [8:0] day_nx;
  logic [8:0] mon_nx;
  logic [8:0] yr_nx;
  logic [7:0] day_last;
  logic [7:0] aw_ext;
  logic al_match;
  logic [15:0][3:0] im;

  rcc_serial u_serial (
    .lk(lk_if.link),
    .sclk(LINK_SCLK),
    .ce(LINK_CE),
    .sio_in(SIO_IN),
    .sio_out(SIO_OUT),
    .sio_oe(SIO_OE)
  );

  // Two-digit BCD step; bit 8 is the carry out on wrap
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    logic [8:0] r;
    if (v == last) begin
      r = {1'b1, first};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction : bcd_step

  // Hour step; result is carry, tens, ones
  function automatic logic [6:0] hour_step(input logic [1:0] t, input logic [3:0] o,
                                           input logic fmt24);
    logic [6:0] r;
    r = {1'b0, t, o + 4'h1};
    if (fmt24) begin
      if (t == 2'h2 && o == 4'h3) begin
        r = {1'b1, 2'h0, 4'h0};
      end else if (o == 4'h9) begin
        r = {1'b0, t + 2'h1, 4'h0};
      end
    end else begin
      // Tens bit1 is the afternoon flag, so noon is 32 and midnight 12
      if (t[0] && o == 4'h2) begin
        r = {1'b0, t[1], 1'b0, 4'h1};
      end else if (t[0] && o == 4'h1) begin
        r = {t[1], ~t[1], 1'b1, 4'h2};
      end else if (o == 4'h9) begin
        r = {1'b0, t[1], 1'b1, 4'h0};
      end
    end
    return r;
  endfunction : hour_step

  function automatic logic is_leap(input logic [7:0] y);
    logic r;
    if (y[4]) begin
      r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    return r;
  endfunction : is_leap

  assign gate = s.cfg_s2[`RCC_CFG_GATE];
  assign h24 = s.cfg_s2[`RCC_CFG_H24];
  assign tick_ev = s.tick_s[1] && !s.tick_s[2];
  assign wr_ev = s.wv_s[1] && !s.wv_s[2];

  assign sec_nx = bcd_step({1'b0, s.st, s.so}, `RCC_SEC_LAST, `RCC_FIRST_ZERO);
  assign min_nx = bcd_step({1'b0, s.mt, s.mo}, `RCC_MIN_LAST, `RCC_FIRST_ZERO);
  assign hr_nx = hour_step(s.ht, s.ho, h24);
  assign day_nx = bcd_step({2'b00, s.dyt, s.dyo}, day_last, `RCC_FIRST_ONE);
  assign mon_nx = bcd_step({3'b000, s.mnt, s.mno}, `RCC_MON_LAST, `RCC_FIRST_ONE);
  assign yr_nx = bcd_step({s.yt, s.yo}, `RCC_YR_LAST, `RCC_FIRST_ZERO);

  always_comb begin
    case ({3'b000, s.mnt, s.mno})
      `RCC_FEB: day_last = is_leap({s.yt, s.yo}) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: day_last = 8'h30;
      default: day_last = 8'h31;
    endcase
  end

  // Code 111 indexes a constant zero, so it can never match
  assign aw_ext = {1'b0, s.aw};
  // Exact compare: an impossible alarm time simply never equals the time
  assign al_match = aw_ext[s.wd]
                    && s.amo == s.mo && s.amt == s.mt
                    && s.aho == s.ho && s.aht == s.ht;

  always_comb begin
    next_s = s;
    im = '0;
    next_s.tick_s = {s.tick_s[1:0], TICK_1HZ};
    next_s.wv_s = {s.wv_s[1:0], lk_if.wr_valid};
    next_s.cfg_s1 = {BANK_SELECT, HOUR_24_MODE, ALARM_ENABLE, ALARM_OUTPUT_HALT,
                     SECOND_CARRY_GATE};
    next_s.cfg_s2 = s.cfg_s1;
    // Count chain: all carries land on the same tick
    if (tick_ev && gate) begin
      next_s.so = sec_nx[3:0];
      next_s.st = sec_nx[6:4];
      if (sec_nx[8]) begin
        next_s.mo = min_nx[3:0];
        next_s.mt = min_nx[6:4];
        if (min_nx[8]) begin
          next_s.ho = hr_nx[3:0];
          next_s.ht = hr_nx[5:4];
          if (hr_nx[6]) begin
            next_s.wd = (s.wd == `RCC_WDAY_LAST) ? 3'h0 : s.wd + 3'h1;
            next_s.dyo = day_nx[3:0];
            next_s.dyt = day_nx[5:4];
            if (day_nx[8]) begin
              next_s.mno = mon_nx[3:0];
              next_s.mnt = mon_nx[4];
              if (mon_nx[8]) begin
                next_s.yo = yr_nx[3:0];
                next_s.yt = yr_nx[7:4];
              end
            end
          end
        end
      end
    end
    // A host write overrides the count of the same cycle; wide bits dropped
    if (wr_ev) begin
      if (!s.cfg_s2[`RCC_CFG_BANK]) begin
        if (lk_if.wr_addr == `RCC_A_SEC_O) begin
          next_s.so = lk_if.wr_data;
        end else if (lk_if.wr_addr == `RCC_A_SEC_T) begin
          next_s.st = lk_if.wr_data[2:0];
        end else if (lk_if.wr_addr == `RCC_A_MIN_O) begin
          next_s.mo = lk_if.wr_data;
        end else if (lk_if.wr_addr == `RCC_A_MIN_T) begin
          next_s.mt = lk_if.wr_data[2:0];
        end else if (lk_if.wr_addr == `RCC_A_HR_O) begin
          next_s.ho = lk_if.wr_data;
        end else if (lk_if.wr_addr == `RCC_A_HR_T) begin
          next_s.ht = lk_if.wr_data[1:0];
        end else if (lk_if.wr_addr == `RCC_A_WDAY) begin
          next_s.wd = lk_if.wr_data[2:0];
        end else if (lk_if.wr_addr == `RCC_A_DAY_O) begin
          next_s.dyo = lk_if.wr_data;
        end else if (lk_if.wr_addr == `RCC_A_DAY_T) begin
          next_s.dyt = lk_if.wr_data[1:0];
        end else if (lk_if.wr_addr == `RCC_A_MON_O) begin
          next_s.mno = lk_if.wr_data;
        end else if (lk_if.wr_addr == `RCC_A_MON_T) begin
          next_s.mnt = lk_if.wr_data[0];
        end else if (lk_if.wr_addr == `RCC_A_YR_O) begin
          next_s.yo = lk_if.wr_data;
        end else if (lk_if.wr_addr == `RCC_A_YR_T) begin
          next_s.yt = lk_if.wr_data;
        end
      end else begin
        if (lk_if.wr_addr == `RCC_A_AW_LO) begin
          next_s.aw[3:0] = lk_if.wr_data;
        end else if (lk_if.wr_addr == `RCC_A_AW_HI) begin
          next_s.aw[6:4] = lk_if.wr_data[2:0];
        end else if (lk_if.wr_addr == `RCC_A_AMIN_O) begin
          next_s.amo = lk_if.wr_data;
        end else if (lk_if.wr_addr == `RCC_A_AMIN_T) begin
          next_s.amt = lk_if.wr_data[2:0];
        end else if (lk_if.wr_addr == `RCC_A_AHR_O) begin
          next_s.aho = lk_if.wr_data;
        end else if (lk_if.wr_addr == `RCC_A_AHR_T) begin
          next_s.aht = lk_if.wr_data[1:0];
        end
      end
    end
    // Interrupt low only while enabled, not halted and matching
    next_s.interrupt_out_n_n = !(s.cfg_s2[`RCC_CFG_ALE]
                      && !s.cfg_s2[`RCC_CFG_HALT]
                      && al_match);
    // Read image of the selected bank, unused bits zero
    if (!s.cfg_s2[`RCC_CFG_BANK]) begin
      im[`RCC_A_SEC_O] = s.so;
      im[`RCC_A_SEC_T] = {1'b0, s.st};
      im[`RCC_A_MIN_O] = s.mo;
      im[`RCC_A_MIN_T] = {1'b0, s.mt};
      im[`RCC_A_HR_O] = s.ho;
      im[`RCC_A_HR_T] = {2'b00, s.ht};
      im[`RCC_A_WDAY] = {1'b0, s.wd};
      im[`RCC_A_DAY_O] = s.dyo;
      im[`RCC_A_DAY_T] = {2'b00, s.dyt};
      im[`RCC_A_MON_O] = s.mno;
      im[`RCC_A_MON_T] = {3'b000, s.mnt};
      im[`RCC_A_YR_O] = s.yo;
      im[`RCC_A_YR_T] = s.yt;
    end else begin
      im[`RCC_A_AW_LO] = s.aw[3:0];
      im[`RCC_A_AW_HI] = {1'b0, s.aw[6:4]};
      im[`RCC_A_AMIN_O] = s.amo;
      im[`RCC_A_AMIN_T] = {1'b0, s.amt};
      im[`RCC_A_AHR_O] = s.aho;
      im[`RCC_A_AHR_T] = {2'b00, s.aht};
    end
    next_s.img = im;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      s <= '0;
      s.dyo <= `RCC_RST_DAY_O;
      s.mno <= `RCC_RST_MON_O;
      s.interrupt_out_n_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign lk_if.rd_image = s.img;
  assign INTERRUPT_OUT_N = s.interrupt_out_n_n;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  logic step;
  assign step = tick_ev && gate && !wr_ev;
  logic day_carry;
  assign day_carry = step && sec_nx[8] && min_nx[8] && hr_nx[6];

  a_sec_freeze: assert property (tick_ev && !gate && !wr_ev |=> $stable({s.st, s.so}))
    else $error("seconds moved with carry gate closed");
  a_sec_wrap: assert property (step && {s.st, s.so} == 7'h59
    |=> {s.st, s.so} == 7'h00 && {s.mt, s.mo} != $past({s.mt, s.mo}))
    else $error("seconds wrap did not reach zero and carry");
  a_min_wrap: assert property (step && sec_nx[8] && {s.mt, s.mo} == 7'h59
    |=> {s.mt, s.mo} == 7'h00 && {s.ht, s.ho} != $past({s.ht, s.ho}))
    else $error("minutes wrap did not reach zero and carry");
  a_hour_carry: assert property (step && sec_nx[8] && min_nx[8] && hr_nx[6]
    |=> {s.dyt, s.dyo} != $past({s.dyt, s.dyo}) && s.wd != $past(s.wd))
    else $error("hour wrap did not carry into day and weekday");
  a_wday_wrap: assert property (step && sec_nx[8] && min_nx[8] && hr_nx[6]
    && s.wd == 3'h6 |=> s.wd == 3'h0)
    else $error("weekday did not return to zero after six");
  a_wday_step: assert property (step && !(sec_nx[8] && min_nx[8] && hr_nx[6])
    |=> $stable(s.wd))
    else $error("weekday moved without a day carry");
  a_midnight_12h: assert property (step && !h24 && s.ht == 2'h3 && s.ho == 4'h1
    && sec_nx[8] && min_nx[8] |=> s.ht == 2'h1 && s.ho == 4'h2)
    else $error("twelve-hour midnight did not read 12");
  a_feb_end: assert property (step && sec_nx[8] && min_nx[8] && hr_nx[6]
    && {s.mnt, s.mno} == 5'h02 && {s.dyt, s.dyo} == 6'h28 && s.yt == 4'h0
    && s.yo == 4'h5 |=> {s.dyt, s.dyo} == 6'h01 && s.mno == 4'h3)
    else $error("ordinary February did not end on 28");
  a_halt_quiet: assert property (s.cfg_s2[`RCC_CFG_HALT] |=> INTERRUPT_OUT_N)
    else $error("interrupt asserted while halted");
  a_ale_off: assert property (!s.cfg_s2[`RCC_CFG_ALE] |=> INTERRUPT_OUT_N)
    else $error("interrupt asserted with alarm disabled");
  a_mask_zero: assert property (s.aw == 7'h00 |=> INTERRUPT_OUT_N)
    else $error("interrupt asserted with empty weekday mask");
  a_alarm_fire: assert property (s.cfg_s2[`RCC_CFG_ALE] && !s.cfg_s2[`RCC_CFG_HALT]
    && al_match |=> !INTERRUPT_OUT_N)
    else $error("matching alarm did not assert interrupt");
  a_pad_zero: assert property (s.img[7] == 1'b0 && s.img[15] == 1'b0
    && s.img[23:22] == 2'b00)
    else $error("unused read bits not zero");
  a_tens_write: assert property (wr_ev && !s.cfg_s2[`RCC_CFG_BANK]
    && lk_if.wr_addr == `RCC_A_SEC_T |=> s.st == $past(lk_if.wr_data[2:0]))
    else $error("seconds tens write did not keep the low three bits");
  a_min_hold: assert property (step && !sec_nx[8] |=> $stable({s.mt, s.mo}))
    else $error("minutes moved without a seconds carry");
  a_hour_wrap_24: assert property (step && sec_nx[8] && min_nx[8] && h24
    && {s.ht, s.ho} == 6'h23 |=> {s.ht, s.ho} == 6'h00)
    else $error("24-hour clock did not wrap from 23 to 00");
  a_noon_12h: assert property (step && !h24 && s.ht == 2'h1 && s.ho == 4'h1
    && sec_nx[8] && min_nx[8] |=> s.ht == 2'h3 && s.ho == 4'h2)
    else $error("twelve-hour noon did not read 32");

  // Calendar boundaries on the day carry, then no interrupt without an alarm match
  a_month_wrap: assert property (day_carry && day_nx[8] && {s.mnt, s.mno} == 5'h12
    |=> {s.mnt, s.mno} == 5'h01 && {s.yt, s.yo} != $past({s.yt, s.yo}))
    else $error("December did not wrap into January and the year");
  a_year_wrap: assert property (day_carry && day_nx[8] && mon_nx[8]
    && {s.yt, s.yo} == 8'h99 |=> {s.yt, s.yo} == 8'h00)
    else $error("year did not wrap from 99 to 00");
  a_leap_feb: assert property (day_carry && {s.mnt, s.mno} == 5'h02
    && {s.dyt, s.dyo} == 6'h29 |=> {s.dyt, s.dyo} == 6'h01 && s.mno == 4'h3)
    else $error("leap February did not end on 29");
  a_day_thirty: assert property (day_carry && {s.dyt, s.dyo} == 6'h30
    && ({s.mnt, s.mno} == 5'h04 || {s.mnt, s.mno} == 5'h06
    || {s.mnt, s.mno} == 5'h09 || {s.mnt, s.mno} == 5'h11) |=> {s.dyt, s.dyo} == 6'h01)
    else $error("thirty-day month did not end on 30");
  a_alarm_miss: assert property (!al_match |=> INTERRUPT_OUT_N)
    else $error("interrupt asserted without an alarm match");

  c_alarm_fire: cover property (INTERRUPT_OUT_N ##1 !INTERRUPT_OUT_N);
  c_year_wrap: cover property (step && sec_nx[8] && min_nx[8] && hr_nx[6]
    && day_nx[8] && mon_nx[8] && yr_nx[8]);
  c_leap_day: cover property (step && {s.mnt, s.mno} == 5'h02 && {s.dyt, s.dyo} == 6'h29);
  c_host_write: cover property (wr_ev);
  c_noon_12h: cover property (step && !h24 && s.ht == 2'h1 && s.ho == 4'h1
    && sec_nx[8] && min_nx[8]);
endmodule : rcc_core

// ===== hdl/rcc_defines.svh
`ifndef RCC_DEFINES_SVH
`define RCC_DEFINES_SVH
// Bank 0 counter offsets
`define RCC_A_SEC_O 4'h0
`define RCC_A_SEC_T 4'h1
`define RCC_A_MIN_O 4'h2
`define RCC_A_MIN_T 4'h3
`define RCC_A_HR_O 4'h4
`define RCC_A_HR_T 4'h5
`define RCC_A_WDAY 4'h6
`define RCC_A_DAY_O 4'h8
`define RCC_A_DAY_T 4'h9
`define RCC_A_MON_O 4'ha
`define RCC_A_MON_T 4'hb
`define RCC_A_YR_O 4'hc
`define RCC_A_YR_T 4'hd
// Bank 1 alarm offsets
`define RCC_A_AW_LO 4'h0
`define RCC_A_AW_HI 4'h1
`define RCC_A_AMIN_O 4'h2
`define RCC_A_AMIN_T 4'h3
`define RCC_A_AHR_O 4'h4
`define RCC_A_AHR_T 4'h5
// Positions in the synchronised control pin vector
`define RCC_CFG_GATE 0
`define RCC_CFG_HALT 1
`define RCC_CFG_ALE 2
`define RCC_CFG_H24 3
`define RCC_CFG_BANK 4
// Counter limits in BCD
`define RCC_SEC_LAST 8'h59
`define RCC_MIN_LAST 8'h59
`define RCC_MON_LAST 8'h12
`define RCC_YR_LAST 8'h99
`define RCC_FIRST_ZERO 8'h00
`define RCC_FIRST_ONE 8'h01
`define RCC_FEB 8'h02
`define RCC_WDAY_LAST 3'h6
// Reset values
`define RCC_RST_DAY_O 4'h1
`define RCC_RST_MON_O 4'h1
// Serial group bit positions
`define RCC_BIT_LAST 3'h7
`define RCC_WV_CLR 3'h3
`define RCC_OE_ON 3'h1
`define RCC_DATA_ON 3'h4
`endif

// ===== hdl/rcc_pkg.sv
package rcc_pkg;
  typedef logic rcc_bit_t;
  typedef enum logic {RCC_PH_CMD, RCC_PH_READ} rcc_phase_t;
  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sh;
    logic [3:0] addr;
    logic [3:0] wdata;
    logic wvalid;
    logic [63:0] img_s1;
    logic [63:0] img_s2;
    rcc_phase_t st;
    logic out;
    logic oe;
  } rcc_link_t;
  typedef struct packed {
    logic [2:0] tick_s;
    logic [2:0] wv_s;
    logic [4:0] cfg_s1;
    logic [4:0] cfg_s2;
    logic [3:0] so;
    logic [2:0] st;
    logic [3:0] mo;
    logic [2:0] mt;
    logic [3:0] ho;
    logic [1:0] ht;
    logic [2:0] wd;
    logic [3:0] dyo;
    logic [1:0] dyt;
    logic [3:0] mno;
    logic mnt;
    logic [3:0] yo;
    logic [3:0] yt;
    logic [6:0] aw;
    logic [3:0] amo;
    logic [2:0] amt;
    logic [3:0] aho;
    logic [1:0] aht;
    logic [63:0] img;
    logic interrupt_out_n_n;
  } rcc_core_t;
endpackage : rcc_pkg

// ===== hdl/rcc_link_if.sv
`timescale 1ns/1ps
interface rcc_link_if;
  logic wr_valid;
  logic [3:0] wr_addr;
  logic [3:0] wr_data;
  logic [63:0] rd_image;
  modport link(output wr_valid, output wr_addr, output wr_data, input rd_image);
  modport core(input wr_valid, input wr_addr, input wr_data, output rd_image);
endinterface : rcc_link_if

// ===== hdl/rcc_serial.sv
`timescale 1ns/1ps
`include "rcc_defines.svh"
module rcc_serial (
  rcc_link_if.link lk, // Words to and from the counter core
  input wire logic sclk, // Serial shift clock
  input wire logic ce, // Frame enable, low clears the link
  input wire logic sio_in, // Serial data from the host
  output logic sio_out, // Serial data to the host
  output logic sio_oe // High while the data pin is driven
);
  import rcc_pkg::*;
  rcc_link_t s;
  rcc_link_t next_s;
  logic [7:0] grp;
  logic [15:0][3:0] img;
  logic [3:0] word;
  assign grp = {s.sh, sio_in};
  assign img = s.img_s2;
  assign word = img[s.addr];
  always_comb begin
    next_s = s;
    next_s.img_s1 = lk.rd_image;
    next_s.img_s2 = s.img_s1;
    next_s.sh = grp[6:0];
    next_s.cnt = s.cnt + 3'h1;
    // Write word stands long enough for the core to see it twice
    if (s.cnt == `RCC_WV_CLR) begin
      next_s.wvalid = 1'b0;
    end
    case (s.st)
      RCC_PH_CMD: begin
        if (s.cnt == `RCC_BIT_LAST && grp[5] && !grp[4]) begin
          next_s.addr = grp[3:0];
          if (grp[6]) begin
            next_s.st = RCC_PH_READ;
          end
        end else if (s.cnt == `RCC_BIT_LAST && grp[4] && !grp[5] && !grp[6]) begin
          next_s.wdata = grp[3:0];
          next_s.wvalid = 1'b1;
        end
      end
      RCC_PH_READ: begin
        if (s.cnt == `RCC_BIT_LAST) begin
          next_s.st = RCC_PH_CMD;
        end
      end
      default: next_s.st = RCC_PH_CMD;
    endcase
    next_s.oe = (s.st == RCC_PH_READ) && (s.cnt >= `RCC_OE_ON);
    if (s.st == RCC_PH_READ && s.cnt >= `RCC_DATA_ON) begin
      next_s.out = word[2'(`RCC_BIT_LAST - s.cnt)];
    end else begin
      next_s.out = 1'b0;
    end
  end
  always_ff @(posedge sclk or negedge ce) begin
    if (!ce) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign lk.wr_valid = s.wvalid;
  assign lk.wr_addr = s.addr;
  assign lk.wr_data = s.wdata;
  assign sio_out = s.out;
  assign sio_oe = s.oe;
endmodule : rcc_serial

// ===== tb/rcc_host_model.sv
`timescale 1ns/1ps
module rcc_host_model (
  output logic link_sclk, // Shift clock, still outside frames
  output logic link_ce, // Frame enable
  output logic sio_in, // Resolved level of the data pin
  input wire logic sio_out, // Device data out
  input wire logic sio_oe // Device drive enable
);
  logic drv;
  // Device wins the pin while it drives, else the host level
  assign sio_in = sio_oe ? sio_out : drv;
  initial begin
    link_sclk = 1'b0;
    link_ce = 1'b1;
    drv = 1'b1;
    // Falling edge once every process waits, so the link starts cleared
    #5 link_ce = 1'b0;
  end
  // One 8-bit group, MSB first; on a read group the host lets go and
  // its own level toggles so stale data cannot pass for an answer
  task automatic group(input logic [7:0] g, input logic rdg, output logic [3:0] d);
    d = 4'h0;
    for (int k = 0; k < 8; k++) begin
      drv = rdg ? ~drv : g[7-k];
      #15 link_sclk = 1'b1;
      #14;
      if (rdg && k >= 4) d[7-k] = sio_oe ? sio_out : 1'bx;
      #1 link_sclk = 1'b0;
    end
  endtask : group
  task automatic wr(input logic [3:0] a, input logic [3:0] v);
    logic [3:0] d;
    link_ce = 1'b1;
    #27;
    group({4'h2, a}, 1'b0, d);
    group({4'h1, v}, 1'b0, d);
    // Idle group gives the write its trailing edges before release
    group(8'h00, 1'b0, d);
    link_ce = 1'b0;
    #60;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [3:0] v);
    link_ce = 1'b1;
    #27;
    group({4'h6, a}, 1'b0, v);
    group(8'h00, 1'b1, v);
    link_ce = 1'b0;
    #60;
  endtask : rd
endmodule : rcc_host_model

// ===== tb/rcc_core_test.sv
`timescale 1ns/1ps
`include "rcc_defines.svh"
module rcc_core_test;
  import rcc_pkg::*;
  logic ref_clk;
  logic srst;
  logic tick;
  logic [4:0] cfg;
  logic link_sclk;
  logic link_ce;
  logic sio_in;
  logic sio_out;
  logic sio_oe;
  logic interrupt_out_n_n;
  logic [31:0] seed;
  logic [25:0] r;
  int errors;
  int num_checks;
  int cycles = 0;
  int m;
  int y;
  int w;
  localparam int cal_mon [4] = '{12, 2, 2, 2};
  localparam int cal_yr [4] = '{99, 0, 5, 96};
  // Fields: mask, alarm hour, alarm minute, enable, halt, expected output
  localparam logic [25:0] alarm_rows [7] = '{
    {7'h02, 8'h32, 8'h00, 3'b100},
    {7'h02, 8'h32, 8'h00, 3'b111},
    {7'h02, 8'h32, 8'h00, 3'b001},
    {7'h00, 8'h32, 8'h00, 3'b101},
    {7'h7d, 8'h32, 8'h00, 3'b101},
    {7'h02, 8'h12, 8'h00, 3'b101},
    {7'h02, 8'h32, 8'h0a, 3'b101}};

  rcc_core dut (
    .REF_CLK(ref_clk), .SRST(srst), .LINK_SCLK(link_sclk), .LINK_CE(link_ce),
    .SIO_IN(sio_in), .SIO_OUT(sio_out), .SIO_OE(sio_oe), .TICK_1HZ(tick),
    .SECOND_CARRY_GATE(cfg[`RCC_CFG_GATE]), .ALARM_OUTPUT_HALT(cfg[`RCC_CFG_HALT]),
    .ALARM_ENABLE(cfg[`RCC_CFG_ALE]), .HOUR_24_MODE(cfg[`RCC_CFG_H24]),
    .BANK_SELECT(cfg[`RCC_CFG_BANK]), .INTERRUPT_OUT_N(interrupt_out_n_n));

  rcc_host_model host (
    .link_sclk(link_sclk), .link_ce(link_ce), .sio_in(sio_in),
    .sio_out(sio_out), .sio_oe(sio_oe));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction : bcd
  function automatic int last_day(input int mo, input int yr);
    if (mo == 2) return (yr % 4 == 0) ? 29 : 28;
    return (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
  endfunction : last_day

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [3:0] a, input logic [3:0] e);
    logic [3:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask : rd_chk
  task automatic rd_pair(input logic [3:0] a, input logic [7:0] e);
    rd_chk(a, e[3:0]);
    rd_chk(a + 4'h1, e[7:4]);
  endtask : rd_pair
  task automatic wr_pair(input logic [3:0] a, input logic [7:0] v);
    host.wr(a, v[3:0]);
    host.wr(a + 4'h1, v[7:4]);
  endtask : wr_pair
  task automatic pins(input logic [4:0] v);
    @(posedge ref_clk);
    cfg <= v;
    repeat (6) @(posedge ref_clk);
  endtask : pins
  task automatic pulse_tick();
    @(posedge ref_clk);
    tick <= 1'b1;
    repeat (3) @(posedge ref_clk);
    tick <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : pulse_tick
  task automatic set_all(input logic [7:0] hr, mn, sc, input int wd, dy, mo, yr);
    wr_pair(`RCC_A_SEC_O, sc);
    wr_pair(`RCC_A_MIN_O, mn);
    wr_pair(`RCC_A_HR_O, hr);
    host.wr(`RCC_A_WDAY, 4'(wd));
    wr_pair(`RCC_A_DAY_O, bcd(dy));
    wr_pair(`RCC_A_MON_O, bcd(mo));
    wr_pair(`RCC_A_YR_O, bcd(yr));
  endtask : set_all
  task automatic chk_all(input logic [7:0] hr, mn, sc, input int wd, dy, mo, yr);
    rd_pair(`RCC_A_SEC_O, sc);
    rd_pair(`RCC_A_MIN_O, mn);
    rd_pair(`RCC_A_HR_O, hr);
    rd_chk(`RCC_A_WDAY, 4'(wd));
    rd_pair(`RCC_A_DAY_O, bcd(dy));
    rd_pair(`RCC_A_MON_O, bcd(mo));
    rd_pair(`RCC_A_YR_O, bcd(yr));
  endtask : chk_all

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, cycles, 0);
      print_verdict();
    end
  end

  initial begin
    srst = 1'b1;
    tick = 1'b0;
    cfg = 5'h00;
    errors = 0;
    num_checks = 0;
    seed = 32'ha927eb70;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    pins(5'h09);
    rd_chk(4'h7, 4'h0);
    host.wr(`RCC_A_MON_T, 4'he);
    rd_chk(`RCC_A_MON_T, 4'h0);
    host.wr(4'he, 4'hf);
    rd_chk(4'he, 4'h0);
    // Midnight roll at the last day of a month, corners first then random
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      m = (i < 4) ? cal_mon[i] : seed[7:0] % 12 + 1;
      y = (i < 4) ? cal_yr[i] : seed[15:8] % 100;
      w = (i == 0) ? 6 : seed[23:16] % 7;
      set_all(8'h23, 8'h59, 8'h59, w, last_day(m, y), m, y);
      pulse_tick();
      w = (w + 1) % 7;
      y = (m == 12) ? (y + 1) % 100 : y;
      chk_all(8'h00, 8'h00, 8'h00, w, 1, m % 12 + 1, y);
    end
    pins(5'h01);
    set_all(8'h31, 8'h59, 8'h59, 3, 30, 6, 10);
    pulse_tick();
    rd_pair(`RCC_A_HR_O, 8'h12);
    rd_pair(`RCC_A_DAY_O, 8'h01);
    rd_pair(`RCC_A_MON_O, 8'h07);
    rd_chk(`RCC_A_WDAY, 4'h4);
    set_all(8'h11, 8'h59, 8'h59, 1, 16, 6, 10);
    pulse_tick();
    rd_pair(`RCC_A_HR_O, 8'h32);
    rd_chk(`RCC_A_WDAY, 4'h1);
    pins(5'h00);
    pulse_tick();
    rd_chk(`RCC_A_SEC_O, 4'h0);
    // Time now stands at noon on weekday code 1
    for (int i = 0; i < 7; i++) begin
      r = alarm_rows[i];
      pins(5'h11);
      host.wr(`RCC_A_AW_LO, r[22:19]);
      host.wr(`RCC_A_AW_HI, {1'b0, r[25:23]});
      wr_pair(`RCC_A_AMIN_O, r[10:3]);
      wr_pair(`RCC_A_AHR_O, r[18:11]);
      pins({2'b00, r[2:1], 1'b1});
      chk({3'h0, interrupt_out_n_n}, {3'h0, r[0]});
    end
    print_verdict();
  end
endmodule : rcc_core_test
